// file: rtl/pts_pkg.sv
// Constants and carrier types for the pacer and trigger source block
package pts_pkg;

  // ****************************************************************
  // Widths, rates and pin positions
  // ****************************************************************
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned NUM_CNT     = 3;
  localparam int unsigned REF_CLK_HZ  = 10_000_000;
  localparam int unsigned INT_CLK_HZ  = 1_000_000;
  localparam int unsigned INT_DIV     = REF_CLK_HZ / INT_CLK_HZ;
  localparam int unsigned PRESC_W     = $clog2(INT_DIV);
  localparam int unsigned NUM_PINS    = 4;

  localparam int unsigned PIN_TRIG    = 0;
  localparam int unsigned PIN_TGATE   = 1;
  localparam int unsigned PIN_ECLK    = 2;
  localparam int unsigned PIN_EGATE   = 3;

  localparam int unsigned CNT_EVENT   = 0;
  localparam int unsigned CNT_PACE_LO = 1;
  localparam int unsigned CNT_PACE_HI = 2;

  // ****************************************************************
  // Values after reset and terminal values
  // ****************************************************************
  localparam logic [CNT_W-1:0]   CNT_RST   = 16'h0000;
  localparam logic [PRESC_W-1:0] PRESC_RST = 4'h0;
  localparam logic [PRESC_W-1:0] PRESC_END = PRESC_W'(INT_DIV - 1);
  localparam logic [CNT_W-1:0]   CNT_TERM  = 16'h0001;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic                          load;
    logic                          event_clk_ext;
    logic                          pacer_run;
    logic                          pacer_out_en;
    logic                          trig_src_ext;
    logic [NUM_CNT-1:0][CNT_W-1:0] divisor;
  } pts_ctrl_t;

  typedef struct packed {
    logic external_trigger_in;
    logic external_trigger_gate;
    logic event_counter_clock_in;
    logic event_counter_gate_in;
  } pts_pins_t;

endpackage

// file: rtl/pts_down_counter.sv
// One 16-bit reloading down counter with a terminal-count pulse
`timescale 1ns/100ps
`default_nettype none

module pts_down_counter #(
  parameter int unsigned W = pts_pkg::CNT_W
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] divisor,
  input  wire logic         tick,
  input  wire logic         gate,
  output logic      [W-1:0] count_q,
  output logic              term_q
);

  // ****************************************************************
  // Count and reload
  // ****************************************************************
  // A divisor of zero wraps through all ones and so divides by 2**W
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      count_q <= W'(pts_pkg::CNT_RST);
      term_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      term_q <= 1'b0;
      if (load)
      begin
        count_q <= divisor;
      end
      else if (tick && gate)
      begin
        if (count_q == W'(pts_pkg::CNT_TERM))
        begin
          count_q <= divisor;
          term_q  <= 1'b1;
        end
        else
        begin
          count_q <= count_q - W'(1);
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/pts_trigger_top.sv
// Pacer, event counter and conversion-start selection for the A/D trigger
`timescale 1ns/100ps
`default_nettype none

module pts_trigger_top (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire pts_pkg::pts_ctrl_t ctrl,
  input  wire pts_pkg::pts_pins_t pins,
  output logic                   conv_start_q,
  output logic                   pacer_out_q,
  output logic                   event_counter_out_q,
  output logic [pts_pkg::CNT_W-1:0] event_count_q
);

  localparam int unsigned N = pts_pkg::NUM_PINS;
  localparam int unsigned W = pts_pkg::CNT_W;

  // ****************************************************************
  // Input synchronisers and edge history
  // ****************************************************************
  logic [N-1:0] pin_raw;
  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] prev_q;
  logic [N-1:0] rise;

  assign pin_raw[pts_pkg::PIN_TRIG]  = pins.external_trigger_in;
  assign pin_raw[pts_pkg::PIN_TGATE] = pins.external_trigger_gate;
  assign pin_raw[pts_pkg::PIN_ECLK]  = pins.event_counter_clock_in;
  assign pin_raw[pts_pkg::PIN_EGATE] = pins.event_counter_gate_in;

  // Field wiring is asynchronous; the first stage feeds only the second
  for (genvar i = 0; i < N; i++)
  begin : g_sync
    always_ff @(posedge ref_clk)
    begin
      if (reset)
      begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
        prev_q[i] <= 1'b0;
      end
      else if (clk_en)
      begin
        meta_q[i] <= pin_raw[i];
        sync_q[i] <= meta_q[i];
        prev_q[i] <= sync_q[i];
      end
    end
    assign rise[i] = sync_q[i] && !prev_q[i];
  end

  // ****************************************************************
  // Internal 1 MHz tick
  // ****************************************************************
  logic [pts_pkg::PRESC_W-1:0] presc_q;
  logic                        int_tick_q;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      presc_q    <= pts_pkg::PRESC_RST;
      int_tick_q <= 1'b0;
    end
    else if (clk_en)
    begin
      int_tick_q <= (presc_q == pts_pkg::PRESC_END);
      if (presc_q == pts_pkg::PRESC_END)
      begin
        presc_q <= pts_pkg::PRESC_RST;
      end
      else
      begin
        presc_q <= presc_q + pts_pkg::PRESC_W'(1);
      end
    end
  end

  // ****************************************************************
  // Counters
  // ****************************************************************
  logic [pts_pkg::NUM_CNT-1:0]        cnt_tick;
  logic [pts_pkg::NUM_CNT-1:0]        cnt_gate;
  logic [pts_pkg::NUM_CNT-1:0]        cnt_term;
  logic [pts_pkg::NUM_CNT-1:0][W-1:0] cnt_value;

  // Event counter: synchronised pin edges or the internal tick
  assign cnt_tick[pts_pkg::CNT_EVENT] = ctrl.event_clk_ext ?
                                        rise[pts_pkg::PIN_ECLK] : int_tick_q;
  assign cnt_gate[pts_pkg::CNT_EVENT] = sync_q[pts_pkg::PIN_EGATE];
  // Low half of the pacer counts every board clock while pacer_run is set
  assign cnt_tick[pts_pkg::CNT_PACE_LO] = ctrl.pacer_run;
  assign cnt_gate[pts_pkg::CNT_PACE_LO] = 1'b1;
  // High half is clocked only by the low half's terminal count
  assign cnt_tick[pts_pkg::CNT_PACE_HI] = cnt_term[pts_pkg::CNT_PACE_LO];
  assign cnt_gate[pts_pkg::CNT_PACE_HI] = 1'b1;

  for (genvar c = 0; c < pts_pkg::NUM_CNT; c++)
  begin : g_cnt
    pts_down_counter #(
      .W (W)
    ) u_cnt (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .load    (ctrl.load),
      .divisor (ctrl.divisor[c]),
      .tick    (cnt_tick[c]),
      .gate    (cnt_gate[c]),
      .count_q (cnt_value[c]),
      .term_q  (cnt_term[c])
    );
  end

  // ****************************************************************
  // Pacer edge and pins
  // ****************************************************************
  logic pacer_prev_q;
  logic pacer_rise;

  // Edge taken on the counter output; a total divide of one gives a
  // constant level and so only a single start
  assign pacer_rise = cnt_term[pts_pkg::CNT_PACE_HI] && !pacer_prev_q;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pacer_prev_q <= 1'b0;
      pacer_out_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      pacer_prev_q <= cnt_term[pts_pkg::CNT_PACE_HI];
      pacer_out_q  <= ctrl.pacer_out_en && cnt_term[pts_pkg::CNT_PACE_HI];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      event_counter_out_q <= 1'b0;
      event_count_q       <= pts_pkg::CNT_RST;
    end
    else if (clk_en)
    begin
      event_counter_out_q <= cnt_term[pts_pkg::CNT_EVENT];
      event_count_q       <= cnt_value[pts_pkg::CNT_EVENT];
    end
  end

  // ****************************************************************
  // Conversion start selection
  // ****************************************************************
  logic ext_start;

  // Gate low masks every trigger edge, not just the current one
  assign ext_start = sync_q[pts_pkg::PIN_TGATE] && rise[pts_pkg::PIN_TRIG];

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      conv_start_q <= 1'b0;
    end
    else if (clk_en)
    begin
      conv_start_q <= ctrl.trig_src_ext ? ext_start : pacer_rise;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_gate_low_blocks;
    (clk_en && ctrl.trig_src_ext && !sync_q[pts_pkg::PIN_TGATE]) |=> !conv_start_q;
  endproperty
  a_gate_low_blocks: assert property (p_gate_low_blocks)
    else $error("conversion started while trigger gate low");

  property p_ext_edge_starts;
    (clk_en && ctrl.trig_src_ext && sync_q[pts_pkg::PIN_TGATE] && rise[pts_pkg::PIN_TRIG])
      |=> conv_start_q;
  endproperty
  a_ext_edge_starts: assert property (p_ext_edge_starts)
    else $error("gated trigger edge did not start conversion");

  property p_pacer_starts;
    (clk_en && !ctrl.trig_src_ext && pacer_rise) |=> conv_start_q;
  endproperty
  a_pacer_starts: assert property (p_pacer_starts)
    else $error("pacer edge did not start conversion");

  property p_only_selected;
    (clk_en && !ctrl.trig_src_ext && !pacer_rise) |=> !conv_start_q;
  endproperty
  a_only_selected: assert property (p_only_selected)
    else $error("unselected source started conversion");

  property p_single_start;
    (conv_start_q && clk_en) |=> !conv_start_q;
  endproperty
  a_single_start: assert property (p_single_start)
    else $error("conversion start longer than one cycle");

  property p_pacer_pin_off;
    (clk_en && !ctrl.pacer_out_en) |=> !pacer_out_q;
  endproperty
  a_pacer_pin_off: assert property (p_pacer_pin_off)
    else $error("pacer pin pulsed while switched off");

  property p_pacer_pin_on;
    (clk_en && ctrl.pacer_out_en && cnt_term[pts_pkg::CNT_PACE_HI]) |=> pacer_out_q;
  endproperty
  a_pacer_pin_on: assert property (p_pacer_pin_on)
    else $error("pacer period missing on pin");

  property p_cascade;
    (clk_en && !ctrl.load && !cnt_term[pts_pkg::CNT_PACE_LO])
      |=> $stable(cnt_value[pts_pkg::CNT_PACE_HI]);
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("pacer high half moved without low half terminal");

  property p_int_tick_rate;
    // Nine quiet samples follow a tick; a frozen prescaler only stretches the gap
    (int_tick_q && clk_en) |=> (!int_tick_q) [*8] ##1 !int_tick_q;
  endproperty
  a_int_tick_rate: assert property (p_int_tick_rate)
    else $error("internal tick faster than one in ten clocks");

  property p_event_out;
    (clk_en && cnt_term[pts_pkg::CNT_EVENT]) |=> event_counter_out_q;
  endproperty
  a_event_out: assert property (p_event_out)
    else $error("event counter terminal not shown on pin");

endmodule

`default_nettype wire

// file: dv/pts_field_model.sv
// Field wiring and conversion-start model facing the trigger block
`timescale 1ns/100ps
`default_nettype none

module pts_field_model (
  input  wire logic ref_clk,
  input  wire logic conv_start_q,
  input  wire logic gate_on,
  output logic      trig,
  output logic      tgate,
  output logic      eclk
);
  int starts = 0;

  // ****************************************************************
  // Wiring side
  // ****************************************************************
  // Gate sits at the enabling level only when asked
  assign tgate = gate_on;

  initial
  begin
    trig = 1'b0;
    eclk = 1'b0;
  end

  always @(posedge ref_clk)
  begin
    if (conv_start_q === 1'b1)
    begin
      starts++;
    end
  end

  // High four clocks, low four between pulses and three after the last: each level outlasts the input synchroniser
  task automatic edges(input bit ext_clk, input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      #10;
      if (ext_clk)
        eclk = 1'b1;
      else
        trig = 1'b1;
      repeat (4) @(posedge ref_clk);
      #10;
      eclk = 1'b0;
      trig = 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: dv/pacer_and_trigger_source_tb_top.sv
// Self-checking bench for the pacer and trigger source block
`timescale 1ns/100ps
`default_nettype none

module pacer_and_trigger_source_tb_top;
  logic                      ref_clk;
  logic                      reset;
  pts_pkg::pts_ctrl_t        ctrl;
  pts_pkg::pts_pins_t        pins;
  logic                      conv_start_q;
  logic                      pacer_out_q;
  logic                      event_counter_out_q;
  logic [pts_pkg::CNT_W-1:0] event_count_q;
  logic                      trig;
  logic                      tgate;
  logic                      eclk;
  logic                      gate_on;
  logic                      egate;
  logic                      clk_en;
  int                        errors = 0;
  int                        num_checks = 0;
  int                        cycles = 0;
  int                        n_pace = 0;
  int                        n_evt = 0;
  int                        b;

  assign pins = {trig, tgate, eclk, egate};

  pts_trigger_top uut (
    .ref_clk             (ref_clk),
    .reset               (reset),
    .clk_en              (clk_en),
    .ctrl                (ctrl),
    .pins                (pins),
    .conv_start_q        (conv_start_q),
    .pacer_out_q         (pacer_out_q),
    .event_counter_out_q (event_counter_out_q),
    .event_count_q       (event_count_q)
  );

  pts_field_model u_field (
    .ref_clk      (ref_clk),
    .conv_start_q (conv_start_q),
    .gate_on      (gate_on),
    .trig         (trig),
    .tgate        (tgate),
    .eclk         (eclk)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // Pulse counting and hang guard
  // ****************************************************************
  always @(posedge ref_clk)
  begin
    cycles++;
    if (pacer_out_q === 1'b1)
      n_pace++;
    if (event_counter_out_q === 1'b1)
      n_evt++;
    if (cycles == 20000)
    begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Four-state arguments so an unknown output cannot pass as zero
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask

  // Loading while stopped, then starting, keeps the pacer phase clean
  task automatic setup(input logic [15:0] d0, input logic run, input logic ext,
                        input logic oen);
    ctrl = '0;
    ctrl.divisor[0] = d0;
    ctrl.divisor[1] = 16'h0002;
    ctrl.divisor[2] = 16'h0003;
    ctrl.trig_src_ext = ext;
    ctrl.pacer_out_en = oen;
    ctrl.load = 1'b1;
    cyc(2);
    ctrl.load = 1'b0;
    ctrl.pacer_run = run;
  endtask

  task automatic t_pacer(input logic oen);
    setup(16'h0003, 1'b1, 1'b0, oen);
    cyc(20);
    b = u_field.starts;
    n_pace = 0;
    cyc(60);
    chk(u_field.starts - b, 10, "pacer starts");
    chk(n_pace, oen ? 10 : 0, "pacer pin pulses");
  endtask

  // Freeze only while both pulses are low, or a held high would be counted
  task automatic t_freeze();
    setup(16'h0003, 1'b1, 1'b0, 1'b1);
    cyc(20);
    while (conv_start_q !== 1'b0 || pacer_out_q !== 1'b0)
      cyc(1);
    clk_en = 1'b0;
    b = u_field.starts;
    n_pace = 0;
    cyc(30);
    chk(u_field.starts - b, 0, "frozen starts");
    chk(n_pace, 0, "frozen pacer pulses");
    clk_en = 1'b1;
    b = u_field.starts;
    n_pace = 0;
    // One frozen cycle, then twelve running ones: two whole pacer periods
    cyc(13);
    chk(u_field.starts - b, 2, "resumed starts");
    chk(n_pace, 2, "resumed pacer pulses");
  endtask

  task automatic t_ext(input logic gate, input logic src, input int exp);
    setup(16'h0003, src, src, 1'b1);
    gate_on = gate;
    cyc(6);
    b = u_field.starts;
    u_field.edges(1'b0, 4);
    cyc(8);
    chk(u_field.starts - b, exp, "external starts");
  endtask

  task automatic t_event(input logic ext);
    egate = 1'b0;
    setup(ext ? 16'h0002 : 16'h0003, 1'b0, 1'b0, 1'b0);
    cyc(3);
    num_checks++;
    if (event_count_q !== (ext ? 16'h0002 : 16'h0003))
    begin
      errors++;
      $display("Error at %0t: event count after load", $time);
    end
    ctrl.event_clk_ext = ext;
    egate = 1'b1;
    cyc(4);
    if (ext)
    begin
      n_evt = 0;
      u_field.edges(1'b1, 6);
      cyc(8);
      chk(n_evt, 3, "external event pulses");
    end
    else
    begin
      cyc(40);
      n_evt = 0;
      cyc(300);
      chk(n_evt, 10, "internal tick pulses");
    end
    egate = 1'b0;
    cyc(4);
    n_evt = 0;
    cyc(100);
    chk(n_evt, 0, "gated off pulses");
  endtask

  initial
  begin
    reset = 1'b1;
    ctrl = '0;
    gate_on = 1'b0;
    egate = 1'b0;
    clk_en = 1'b1;
    repeat (16) @(posedge ref_clk);
    #10;
    reset = 1'b0;
    cyc(1);
    chk({29'h0, conv_start_q, pacer_out_q, event_counter_out_q}, 0, "pulses after reset");
    chk({16'h0, event_count_q}, 0, "count after reset");
    t_pacer(1'b1);
    t_pacer(1'b0);
    t_freeze();
    t_ext(1'b1, 1'b1, 4);
    t_ext(1'b0, 1'b1, 0);
    t_ext(1'b1, 1'b0, 0);
    t_event(1'b0);
    t_event(1'b1);
    test_done();
  end
endmodule
`default_nettype wire
